/* common/usif_pkg.sv */
// Behaviour
// [R1] State change updates field, sets state flag
// [R2] Software clears state flag before next change
// [R3] Stage change updates field, sets stage flag
// [R4] Software clears stage flag before next stage
// [R5] Empty summary set by enabled empty pipe
// [R6] Empty summary clears only via pipe bits
// [R7] Not-ready summary: any enabled, not writable
// [R8] Ready summary: any enabled, not writable
// [R9] Over-current flag on either pin change
// [R10] Port status flag bit positions fixed
// [R11] Unassigned port status bits read zero
// [R12] Port interrupts enabled only in host mode; the code enables them in either mode
// [R13] Write zero clears, write one keeps
// [R14] Over-current, line change detected clock stopped
// [R15] Other port flags need running clock
// [R16] Software clears stopped-clock flags after restart
// [R17] Enabled set flag asserts interrupt low
// [R18] Interrupt holds until enabled flags clear
package usif_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_PERIPH_STATUS = 8'h40;
    localparam logic [7:0] ADDR_PORT_STATUS   = 8'h42;
    localparam logic [7:0] ADDR_PERIPH_ENABLE = 8'h48;
    localparam logic [7:0] ADDR_PORT_ENABLE   = 8'h4c;
    localparam logic [7:0] ADDR_EMPTY_STATUS  = 8'h50;
    localparam logic [7:0] ADDR_EMPTY_ENABLE  = 8'h54;
    localparam logic [7:0] ADDR_NOT_READY_SUMMARY_STATUS   = 8'h58;
    localparam logic [7:0] ADDR_NOT_READY_SUMMARY_ENABLE   = 8'h5c;
    localparam logic [7:0] ADDR_RDY_STATUS    = 8'h60;
    localparam logic [7:0] ADDR_RDY_ENABLE    = 8'h64;
    localparam logic [7:0] ADDR_CONTROL       = 8'h68;
    // Port status bit positions.
    localparam int BIT_OVERCURRENT = 15;
    localparam int BIT_LINE_CHANGE = 14;
    localparam int BIT_DETACH      = 12;
    localparam int BIT_ATTACH      = 11;
    localparam int BIT_FRAME_ERR   = 6;
    localparam int BIT_SETUP_ERR   = 5;
    localparam int BIT_SETUP_ACK   = 4;
    localparam logic [15:0] PORT_MASK = 16'hd870;
    // Peripheral status layout.
    localparam int BIT_STATE_CHG  = 12;
    localparam int BIT_STAGE_CHG  = 11;
    localparam int BIT_EMPTY_SUM  = 10;
    localparam int BIT_NOT_READY_SUMMARY_SUM   = 9;
    localparam int BIT_RDY_SUM    = 8;
    localparam int POS_STATE      = 4;
    localparam int POS_STAGE      = 0;
    localparam logic [15:0] PERIPH_CLR_MASK = 16'h1800;
    localparam logic [15:0] RESET_VALUE     = 16'h0000;
    localparam logic [1:0]  AXI_OKAY        = 2'b00;
    localparam logic [1:0]  AXI_SLVERR      = 2'b10;
    // Hardware event inputs grouped together.
    typedef struct packed {
        logic       detach;
        logic       attach;
        logic       frame_err;
        logic       setup_err;
        logic       setup_ack;
        logic       line_change;
    } usif_port_ev_t;
    typedef struct packed {
        logic [2:0] device_state;
        logic [2:0] control_stage;
    } usif_periph_t;
endpackage

/* logic/usif_flags.sv */
`timescale 1ns/100ps
module usif_flags #(
    parameter int PIPES = 10
) (
    // Clock and reset.
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write channels.
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Controller events.
    input  wire usif_pkg::usif_periph_t periph_in,
    input  wire usif_pkg::usif_port_ev_t port_ev,
    input  wire logic [PIPES-1:0]       pipe_empty_set,
    input  wire logic [PIPES-1:0]       pipe_notready_set,
    input  wire logic [PIPES-1:0]       pipe_ready_set,
    input  wire logic                   overcurrent_in_a,
    input  wire logic                   overcurrent_in_b,
    // Interrupt output.
    output logic                        int_n
);
    logic              aw_held;
    logic              w_held;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              do_write;
    logic [15:0]       wd;
    logic [15:0]       port_status;
    logic [15:0]       port_enable;
    logic [15:0]       periph_enable;
    logic              state_change_flag;
    logic              stage_change_flag;
    usif_pkg::usif_periph_t periph_q;
    logic [PIPES-1:0]  pipe_empty_flags;
    logic [PIPES-1:0]  pipe_empty_enables;
    logic [PIPES-1:0]  pipe_notready_flags;
    logic [PIPES-1:0]  pipe_notready_enables;
    logic [PIPES-1:0]  pipe_ready_flags;
    logic [PIPES-1:0]  pipe_ready_enables;
    logic              internal_clock_enable;
    logic              host_mode;
    logic              oc_a_q;
    logic              oc_b_q;
    logic              buffer_empty_summary;
    logic              not_ready_summary;
    logic              buffer_ready_summary;
    logic [15:0]       periph_status;
    logic [15:0]       port_set;
    logic [31:0]       next_rdata;
    logic              addr_ok;

    // Write address and data are taken in either order and held until both arrived.
    // Nothing new is taken while a response waits.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign wd            = w_data[15:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    // Address decode shared by write and read.
    // Stray accesses answer with an error.
    function automatic logic known(input logic [7:0] a);
        known = (a == usif_pkg::ADDR_PERIPH_STATUS) || (a == usif_pkg::ADDR_PORT_STATUS)
             || (a == usif_pkg::ADDR_PERIPH_ENABLE) || (a == usif_pkg::ADDR_PORT_ENABLE)
             || (a == usif_pkg::ADDR_EMPTY_STATUS)  || (a == usif_pkg::ADDR_EMPTY_ENABLE)
             || (a == usif_pkg::ADDR_NOT_READY_SUMMARY_STATUS)   || (a == usif_pkg::ADDR_NOT_READY_SUMMARY_ENABLE)
             || (a == usif_pkg::ADDR_RDY_STATUS)    || (a == usif_pkg::ADDR_RDY_ENABLE)
             || (a == usif_pkg::ADDR_CONTROL);
    endfunction

    // Write response, one cycle after both halves are held.
    // An unmapped write completes with no effect.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= usif_pkg::AXI_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known(aw_addr) ? usif_pkg::AXI_OKAY : usif_pkg::AXI_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control and enable registers written by software; low two strobes cover the data.
    // A write with one low strobe is ignored.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_enable           <= usif_pkg::RESET_VALUE;
            periph_enable         <= usif_pkg::RESET_VALUE;
            pipe_empty_enables    <= '0;
            pipe_notready_enables <= '0;
            pipe_ready_enables    <= '0;
            internal_clock_enable <= 1'b0;
            host_mode             <= 1'b0;
        end
        else if (do_write && w_strb[1:0] == 2'b11)
        begin
            case (aw_addr)
                usif_pkg::ADDR_PORT_ENABLE:   port_enable <= wd & usif_pkg::PORT_MASK;
                usif_pkg::ADDR_PERIPH_ENABLE: periph_enable <= wd;
                usif_pkg::ADDR_EMPTY_ENABLE:  pipe_empty_enables <= wd[PIPES-1:0];
                usif_pkg::ADDR_NOT_READY_SUMMARY_ENABLE:   pipe_notready_enables <= wd[PIPES-1:0];
                usif_pkg::ADDR_RDY_ENABLE:    pipe_ready_enables <= wd[PIPES-1:0];
                usif_pkg::ADDR_CONTROL:
                begin
                    internal_clock_enable <= wd[0];
                    host_mode             <= wd[1];
                end
                default: ;
            endcase
        end
    end

    // Peripheral state and stage fields with their change flags; set wins over clear.
    // In host mode only the fields move.
    // The fields lag the inputs by one edge.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            periph_q          <= '0;
            state_change_flag <= 1'b0;
            stage_change_flag <= 1'b0;
        end
        else
        begin
            periph_q <= periph_in; // [R1] [R3]
            if (!host_mode && periph_in.device_state != periph_q.device_state)
                state_change_flag <= 1'b1; // [R1]
            else if (do_write && aw_addr == usif_pkg::ADDR_PERIPH_STATUS
                     && w_strb[1] && !wd[usif_pkg::BIT_STATE_CHG])
                state_change_flag <= 1'b0;
            if (!host_mode && periph_in.control_stage != periph_q.control_stage)
                stage_change_flag <= 1'b1; // [R3]
            else if (do_write && aw_addr == usif_pkg::ADDR_PERIPH_STATUS
                     && w_strb[1] && !wd[usif_pkg::BIT_STAGE_CHG])
                stage_change_flag <= 1'b0;
        end
    end

    // Per-pipe status bits: hardware sets, software writes zero to clear, set wins.
    // Written bits above the pipe count are ignored.
    generate
        for (genvar p = 0; p < PIPES; p++)
        begin : g_pipe
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    pipe_empty_flags[p]    <= 1'b0;
                    pipe_notready_flags[p] <= 1'b0;
                    pipe_ready_flags[p]    <= 1'b0;
                end
                else
                begin
                    if (pipe_empty_set[p])
                        pipe_empty_flags[p] <= 1'b1;
                    else if (do_write && aw_addr == usif_pkg::ADDR_EMPTY_STATUS && !wd[p])
                        pipe_empty_flags[p] <= 1'b0; // [R6]
                    if (pipe_notready_set[p])
                        pipe_notready_flags[p] <= 1'b1;
                    else if (do_write && aw_addr == usif_pkg::ADDR_NOT_READY_SUMMARY_STATUS && !wd[p])
                        pipe_notready_flags[p] <= 1'b0; // [R7]
                    if (pipe_ready_set[p])
                        pipe_ready_flags[p] <= 1'b1;
                    else if (do_write && aw_addr == usif_pkg::ADDR_RDY_STATUS && !wd[p])
                        pipe_ready_flags[p] <= 1'b0; // [R8]
                end
            end
        end
    endgenerate

    // Summaries follow the enabled per-pipe bits only, so direct writes have no effect.
    // A disabled pipe keeps its bit but does not count.
    assign buffer_empty_summary = |(pipe_empty_flags & pipe_empty_enables);       // [R5] [R6]
    assign not_ready_summary    = |(pipe_notready_flags & pipe_notready_enables); // [R7]
    assign buffer_ready_summary = |(pipe_ready_flags & pipe_ready_enables);       // [R8]

    // Peripheral status word as software reads it.
    // The summaries are formed here, never stored.
    always_comb
    begin
        periph_status = 16'h0000;
        periph_status[usif_pkg::BIT_STATE_CHG] = state_change_flag;
        periph_status[usif_pkg::BIT_STAGE_CHG] = stage_change_flag;
        periph_status[usif_pkg::BIT_EMPTY_SUM] = buffer_empty_summary;
        periph_status[usif_pkg::BIT_NOT_READY_SUMMARY_SUM]  = not_ready_summary;
        periph_status[usif_pkg::BIT_RDY_SUM]   = buffer_ready_summary;
        periph_status[usif_pkg::POS_STATE +: 3] = periph_q.device_state;  // [R1]
        periph_status[usif_pkg::POS_STAGE +: 3] = periph_q.control_stage; // [R3]
    end

    // Over-current pins are edge detected; the previous levels are kept for comparison.
    // A pin high when reset ends sets the flag once.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            oc_a_q <= 1'b0;
            oc_b_q <= 1'b0;
        end
        else
        begin
            oc_a_q <= overcurrent_in_a;
            oc_b_q <= overcurrent_in_b;
        end
    end

    // Port events: two always detected, the rest only while the clock runs.
    // This lets a stopped port still wake software.
    always_comb
    begin
        port_set = 16'h0000;
        port_set[usif_pkg::BIT_OVERCURRENT] = (overcurrent_in_a ^ oc_a_q)
                                            | (overcurrent_in_b ^ oc_b_q);   // [R9] [R14]
        port_set[usif_pkg::BIT_LINE_CHANGE] = port_ev.line_change;          // [R14]
        port_set[usif_pkg::BIT_DETACH]    = port_ev.detach & internal_clock_enable;    // [R15]
        port_set[usif_pkg::BIT_ATTACH]    = port_ev.attach & internal_clock_enable;    // [R15]
        port_set[usif_pkg::BIT_FRAME_ERR] = port_ev.frame_err & internal_clock_enable; // [R15]
        port_set[usif_pkg::BIT_SETUP_ERR] = port_ev.setup_err & internal_clock_enable; // [R15]
        port_set[usif_pkg::BIT_SETUP_ACK] = port_ev.setup_ack & internal_clock_enable; // [R15]
    end

    // Port status: write zero clears, write one keeps, new events win, spare bits stay zero.
    // An event during read-modify-write is not lost.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            port_status <= usif_pkg::RESET_VALUE;
        else if (do_write && aw_addr == usif_pkg::ADDR_PORT_STATUS && w_strb[1:0] == 2'b11)
            port_status <= ((port_status & wd) | port_set) & usif_pkg::PORT_MASK; // [R13] [R11]
        else
            port_status <= (port_status | port_set) & usif_pkg::PORT_MASK; // [R10] [R11]
    end

    // Interrupt is low while any enabled flag stands.
    // Registered, so the pin cannot glitch.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            int_n <= 1'b1;
        else
            int_n <= !(|(port_status & port_enable) | |(periph_status[12:8]
                       & periph_enable[12:8])); // [R17] [R18]
    end

    // Read channel: one-cycle answer, unmapped address returns SLVERR and zero.
    // One read at a time: no address while data waits.
    assign s_axi_arready = !s_axi_rvalid;
    assign addr_ok       = known(s_axi_araddr);

    // Read word chosen from the offered address.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (s_axi_araddr)
            usif_pkg::ADDR_PERIPH_STATUS: next_rdata[15:0] = periph_status;
            usif_pkg::ADDR_PORT_STATUS:   next_rdata[15:0] = port_status;
            usif_pkg::ADDR_PERIPH_ENABLE: next_rdata[15:0] = periph_enable;
            usif_pkg::ADDR_PORT_ENABLE:   next_rdata[15:0] = port_enable;
            usif_pkg::ADDR_EMPTY_STATUS:  next_rdata[PIPES-1:0] = pipe_empty_flags;
            usif_pkg::ADDR_EMPTY_ENABLE:  next_rdata[PIPES-1:0] = pipe_empty_enables;
            usif_pkg::ADDR_NOT_READY_SUMMARY_STATUS:   next_rdata[PIPES-1:0] = pipe_notready_flags;
            usif_pkg::ADDR_NOT_READY_SUMMARY_ENABLE:   next_rdata[PIPES-1:0] = pipe_notready_enables;
            usif_pkg::ADDR_RDY_STATUS:    next_rdata[PIPES-1:0] = pipe_ready_flags;
            usif_pkg::ADDR_RDY_ENABLE:    next_rdata[PIPES-1:0] = pipe_ready_enables;
            usif_pkg::ADDR_CONTROL:
                next_rdata[1:0] = {host_mode, internal_clock_enable};
            default: ;
        endcase
    end

    // Read answer captured when the address is taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= usif_pkg::AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= addr_ok ? usif_pkg::AXI_OKAY : usif_pkg::AXI_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // usif_flags

/* bench/usif_flags_checker.sv */
`timescale 1ns/100ps
// Watches the register bus handshakes and the interrupt pin of the flag block.
module usif_flags_checker (
    // Clock and reset.
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus.
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Interrupt output.
    input wire logic        int_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Read data follows by one edge, a write response by two; both stand until taken.
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("Write response did not follow the write.");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data did not follow the read.");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before it was taken.");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped or changed before it was taken.");
    a_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address taken while read data pending.");
    // Spare port status bits read zero and a read of unmapped address 8'h44 answers with an error.
    a_spare_zero: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == usif_pkg::ADDR_PORT_STATUS
        |=> (s_axi_rdata & ~{16'h0000, usif_pkg::PORT_MASK}) == 32'h0)
        else $error("Spare port status bits read as one.");
    a_unmapped_err: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h44
        |=> s_axi_rresp == usif_pkg::AXI_SLVERR && s_axi_rdata == 32'h0)
        else $error("Unmapped read did not return an error.");
    // The interrupt only releases after software wrote something.
    a_int_release: assert property (
        $rose(int_n) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("Interrupt released without a register write.");
endmodule // usif_flags_checker

bind usif_flags usif_flags_checker chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .int_n(int_n)
);

/* bench/usif_flags_tb.sv */
`timescale 1ns/100ps
// Register level bench for the interrupt flag block.
module usif_flags_tb;
    // Stimulus and observed signals.
    logic                    aclk, aresetn, awvalid, awready, wvalid, wready;
    logic                    bvalid, bready, arvalid, arready, rvalid, rready;
    logic                    overcurrent_in_a, overcurrent_in_b, int_n;
    logic [1:0]              bresp, rresp, last_resp;
    logic [3:0]              wstrb;
    logic [7:0]              awaddr, araddr;
    logic [31:0]             wdata, rdata, exp_val, sum;
    logic [29:0]             pipe_set;
    usif_pkg::usif_periph_t  periph;
    usif_pkg::usif_port_ev_t port_ev;
    int                      error_cnt, checks;
    int                      pos [6] = '{14, 4, 5, 6, 11, 12};

    usif_flags #(.PIPES(10)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .periph_in(periph), .port_ev(port_ev), .pipe_empty_set(pipe_set[9:0]),
        .pipe_notready_set(pipe_set[19:10]), .pipe_ready_set(pipe_set[29:20]),
        .overcurrent_in_a(overcurrent_in_a), .overcurrent_in_b(overcurrent_in_b),
        .int_n(int_n)
    );

    // Free running clock.
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Waits one edge; a wait that runs too long ends the run as a failure.
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 100)
        begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    // One write: address and data offered together, each released when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic aw_on;
        logic w_on;
        n = 0;
        aw_on = 1'b1;
        w_on = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_on || w_on)
        begin
            tick(n);
            aw_on = aw_on && (awready !== 1'b1);
            w_on = w_on && (wready !== 1'b1);
            awvalid <= aw_on;
            wvalid <= w_on;
        end
        while (bvalid !== 1'b1)
            tick(n);
        last_resp = bresp;
    endtask

    // One read whose data is compared with the expected word.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        tick(n);
        while (arready !== 1'b1)
            tick(n);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            tick(n);
        last_resp = rresp;
        chk(rdata, want);
    endtask

    // Main sequence of register scenarios.
    initial
    begin
        {aresetn, awvalid, wvalid, arvalid} = '0;
        {bready, rready} = 2'b11; // Answers are taken at the first edge after they appear.
        {overcurrent_in_a, overcurrent_in_b, periph, port_ev, pipe_set} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        error_cnt = 0;
        checks = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(usif_pkg::ADDR_PORT_STATUS, 32'h0);
        chk({31'h0, int_n}, 32'h1);
        axi_wr(usif_pkg::ADDR_CONTROL, 32'h1);
        axi_wr(usif_pkg::ADDR_PERIPH_ENABLE, 32'h1f00);
        // Device state and control stage change together, then are cleared one by one.
        periph <= 6'b011010;
        repeat (2) @(posedge aclk);
        rd_chk(usif_pkg::ADDR_PERIPH_STATUS, 32'h1832);
        chk({31'h0, int_n}, 32'h0);
        axi_wr(usif_pkg::ADDR_PERIPH_STATUS, 32'hefff);
        rd_chk(usif_pkg::ADDR_PERIPH_STATUS, 32'h0832);
        chk({31'h0, int_n}, 32'h0);
        axi_wr(usif_pkg::ADDR_PERIPH_STATUS, 32'h0);
        rd_chk(usif_pkg::ADDR_PERIPH_STATUS, 32'h0032);
        chk({31'h0, int_n}, 32'h1);
        // Empty, not-ready and ready summaries from enabled pipes only.
        for (int k = 0; k < 3; k++)
        begin
            sum = 32'h32 | (32'h400 >> k);
            pipe_set <= 30'(10'h201) << (10 * k);
            @(posedge aclk);
            pipe_set <= '0;
            rd_chk(usif_pkg::ADDR_PERIPH_STATUS, 32'h32);
            axi_wr(8'(usif_pkg::ADDR_EMPTY_ENABLE + 8 * k), 32'h200);
            rd_chk(usif_pkg::ADDR_PERIPH_STATUS, sum);
            chk({31'h0, int_n}, 32'h0);
            axi_wr(usif_pkg::ADDR_PERIPH_STATUS, 32'h0);
            rd_chk(usif_pkg::ADDR_PERIPH_STATUS, sum);
            rd_chk(8'(usif_pkg::ADDR_EMPTY_STATUS + 8 * k), 32'h201);
            axi_wr(8'(usif_pkg::ADDR_EMPTY_STATUS + 8 * k), 32'hfdff);
            rd_chk(usif_pkg::ADDR_PERIPH_STATUS, 32'h32);
            chk({31'h0, int_n}, 32'h1);
        end
        // Host mode: state changes move the fields only; port interrupts may be enabled.
        axi_wr(usif_pkg::ADDR_CONTROL, 32'h3);
        periph <= 6'b001001;
        repeat (2) @(posedge aclk);
        rd_chk(usif_pkg::ADDR_PERIPH_STATUS, 32'h11);
        // Each port event lands on its own bit; ones keep it, a zero clears it.
        axi_wr(usif_pkg::ADDR_PORT_ENABLE, {16'h0, usif_pkg::PORT_MASK});
        for (int i = 0; i < 6; i++)
        begin
            exp_val = 32'h1 << pos[i];
            port_ev <= 6'(1 << i);
            @(posedge aclk);
            port_ev <= '0;
            rd_chk(usif_pkg::ADDR_PORT_STATUS, exp_val);
            chk({31'h0, int_n}, 32'h0);
            axi_wr(usif_pkg::ADDR_PORT_STATUS, {16'h0, usif_pkg::PORT_MASK});
            rd_chk(usif_pkg::ADDR_PORT_STATUS, exp_val);
            axi_wr(usif_pkg::ADDR_PORT_STATUS, {16'h0, usif_pkg::PORT_MASK} & ~exp_val);
            rd_chk(usif_pkg::ADDR_PORT_STATUS, 32'h0);
            chk({31'h0, int_n}, 32'h1);
        end
        // Rising and falling edges of both over-current pins.
        for (int j = 0; j < 4; j++)
        begin
            if (j % 2 == 0)
                overcurrent_in_a <= ~overcurrent_in_a;
            else
                overcurrent_in_b <= ~overcurrent_in_b;
            repeat (2) @(posedge aclk);
            rd_chk(usif_pkg::ADDR_PORT_STATUS, 32'h8000);
            axi_wr(usif_pkg::ADDR_PORT_STATUS, 32'h5870);
            rd_chk(usif_pkg::ADDR_PORT_STATUS, 32'h0);
        end
        // With the clock stopped only over-current and line change are caught.
        axi_wr(usif_pkg::ADDR_CONTROL, 32'h2);
        port_ev <= 6'h3f;
        overcurrent_in_a <= 1'b1;
        @(posedge aclk);
        port_ev <= '0;
        rd_chk(usif_pkg::ADDR_PORT_STATUS, 32'hc000);
        chk({31'h0, int_n}, 32'h0);
        axi_wr(usif_pkg::ADDR_CONTROL, 32'h3);
        axi_wr(usif_pkg::ADDR_PORT_STATUS, 32'h0);
        rd_chk(usif_pkg::ADDR_PORT_STATUS, 32'h0);
        chk({31'h0, int_n}, 32'h1);
        rd_chk(8'h44, 32'h0);
        chk({30'h0, last_resp}, {30'h0, usif_pkg::AXI_SLVERR});
        axi_wr(8'h44, 32'h0);
        chk({30'h0, last_resp}, {30'h0, usif_pkg::AXI_SLVERR});
        report_and_stop();
    end
endmodule // usif_flags_tb
